/* File: hw/cop_defs.svh */
`ifndef COP_DEFS_SVH
`define COP_DEFS_SVH

// register byte offsets
`define OFS_CAUSE        8'h00
`define OFS_OPT1         8'h04
`define OFS_OPT2         8'h08
`define OFS_IOCTL        8'h0c
`define OFS_CPU          8'h10

// system_options_one fields
`define OPT1_EN_BIT      7
`define OPT1_LONG_BIT    6
`define OPT1_PINRST_BIT  1
`define OPT1_RESET       8'hc0
// system_options_two fields
`define OPT2_CLKSEL_BIT  7
`define OPT2_RESET       8'h00

// reset_cause_register fields
`define CAUSE_POR_BIT    7
`define CAUSE_PIN_BIT    6
`define CAUSE_WDOG_BIT   5
`define CAUSE_BADOP_BIT  4
`define CAUSE_BADADR_BIT 3
`define CAUSE_LVD_BIT    1
`define CAUSE_POR_ONLY   8'h80

// io control and cpu state fields
`define IOCTL_PERIPH_BIT 16
`define IOCTL_RESET      17'h00000
`define CPU_UNMASK_BIT   0
`define CPU_MASK_BIT     16
`define CPU_RUN_BIT      17

// cpu reset state
`define VECTOR_HI_ADDR   16'hfffe
`define VECTOR_LO_ADDR   16'hffff
`define STACK_RESET      16'h00ff

// timing
`define CLK_MHZ          250
`define LPO_KHZ          1
`define LPO_DIV          ((`CLK_MHZ * 1000) / `LPO_KHZ)
`define LPO_W            18
`define RST_HOLD_NS      32
`define RST_HOLD_CYC     ((`RST_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define HOLD_W           4

// watchdog overflow exponents
`define LPO_SHORT_LOG2   5'd5
`define LPO_LONG_LOG2    5'd8
`define BUS_SHORT_LOG2   5'd13
`define BUS_LONG_LOG2    5'd18
`define CNT_W            19

`endif

/* File: hw/cop_pkg.sv */
package cop_pkg;

  typedef enum logic [2:0]
  {
    ST_HOLD     = 3'b000,
    ST_FETCH_HI = 3'b001,
    ST_FETCH_LO = 3'b011,
    ST_LOAD     = 3'b010,
    ST_RUN      = 3'b110
  } seq_state_t;

endpackage

/* File: hw/wdog_counter.sv */
`include "cop_defs.svh"

module wdog_counter
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_1k_i,
  input  wire logic clock_select_i,
  input  wire logic timeout_long_i,
  input  wire logic enable_i,
  input  wire logic debug_i,
  input  wire logic stop_i,
  input  wire logic clear_i,
  output logic      overflow_o
);

  logic [`CNT_W-1:0] cnt_q;
  logic [`CNT_W-1:0] cnt_d;
  logic              stop_q;
  logic              ovf_q;

  wire       stop_entry = stop_i & ~stop_q;
  // overflow count follows the live selection
  wire [4:0] lg_w = clock_select_i
                    ? (timeout_long_i ? `BUS_LONG_LOG2 : `BUS_SHORT_LOG2)
                    : (timeout_long_i ? `LPO_LONG_LOG2 : `LPO_SHORT_LOG2);
  wire [`CNT_W-1:0] top_w = (`CNT_W'(1) << lg_w) - `CNT_W'(1);
  // no advance in debug; bus clock holds in stop
  wire adv_w = enable_i & ~debug_i
               & (clock_select_i ? ~stop_i : tick_1k_i);
  // 1 khz source: zero on stop entry and held there
  wire lpo_stop_w = ~clock_select_i & (stop_entry | stop_i);
  wire clr_w = clear_i | ~enable_i | lpo_stop_w;
  wire hit_w = adv_w & (cnt_q >= top_w);

  always_comb
  begin
    cnt_d = cnt_q;
    if (clr_w)
    begin
      cnt_d = '0;
    end
    else if (hit_w)
    begin
      cnt_d = '0;
    end
    else if (adv_w)
    begin
      cnt_d = cnt_q + `CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= '0;
      stop_q <= 1'b0;
      ovf_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      stop_q <= stop_i;
      ovf_q  <= hit_w & ~clr_w;
    end
  end

  assign overflow_o = ovf_q;

endmodule

/* File: hw/cop_watchdog_reset_control.sv */
// What this block does
// - any reset reinitialises registers, disables peripherals, pins inputs, pullups off.
// - after reset the program counter loads from fffe (high) and ffff (low).
// - reset sets the stack pointer to 00ff and sets the interrupt mask.
// - the external reset pin acts only while pin_reset_enable is set.
// - each reset source but debug force records its own cause bit.
// - an unserviced enabled watchdog reaching its overflow count resets the system.
// - watchdog enable is set after every reset; clearing it stops the watchdog.
// - any write to the reset cause address clears the watchdog counter only.
// - clock select picks the 1 khz source at 0, bus clock at 1.
// - on the 1 khz source overflow is 2^5 or 2^8 cycles.
// - on the bus clock overflow is 2^13 or 2^18 cycles.
// - reset defaults give the 1 khz source with the long count.
// - both option registers take one write after reset, then lock.
// - the first write to either option register clears the watchdog.
// - the watchdog counter does not advance in background debug mode.
// - on the bus clock the counter holds during stop, then resumes.
// - on the 1 khz source the counter zeroes on stop entry.
`include "cop_defs.svh"

module cop_watchdog_reset_control
  import cop_pkg::*;
#(
  parameter int LPO_DIVIDE = `LPO_DIV
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ext_reset_n_i,
  input  wire logic        por_i,
  input  wire logic        low_voltage_reset_i,
  input  wire logic        bad_opcode_reset_i,
  input  wire logic        bad_address_reset_i,
  input  wire logic        debug_force_reset_i,
  input  wire logic        debug_mode_i,
  input  wire logic        stop_mode_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic      [15:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             system_reset_o,
  output logic             cpu_run_o,
  output logic      [15:0] pc_o,
  output logic      [15:0] stack_pointer_o,
  output logic             int_mask_o,
  output logic             periph_enable_o,
  output logic      [7:0]  pin_oe_o,
  output logic      [7:0]  pin_pullup_o
);

  seq_state_t            state_q;
  seq_state_t            state_d;
  logic [`HOLD_W-1:0]    hold_q;
  logic [`HOLD_W-1:0]    hold_d;
  logic [7:0]            cause_q;
  logic [7:0]            opt1_q;
  logic [7:0]            opt2_q;
  logic                  opt1_lock_q;
  logic                  opt2_lock_q;
  logic [16:0]           ioctl_q;
  logic [15:0]           pc_q;
  logic [15:0]           sp_q;
  logic                  mask_q;
  logic                  run_q;
  logic                  sysrst_q;
  logic [15:0]           maddr_q;
  logic                  mrd_q;
  logic                  ack_q;
  logic [31:0]           dat_q;
  logic [`LPO_W-1:0]     lpo_q;
  logic                  tick_q;
  logic                  wdog_ovf;

  localparam logic [`HOLD_W-1:0] HOLD_LAST =
    `HOLD_W'(`RST_HOLD_CYC - 1);
  localparam logic [`LPO_W-1:0] LPO_LAST = `LPO_W'(LPO_DIVIDE - 1);

  // bus decode
  wire acc_w    = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_w     = acc_w & wb_we_i;
  wire hit_cause = wb_adr_i == `OFS_CAUSE;
  wire hit_opt1  = wb_adr_i == `OFS_OPT1;
  wire hit_opt2  = wb_adr_i == `OFS_OPT2;
  wire hit_ioctl = wb_adr_i == `OFS_IOCTL;
  wire hit_cpu   = wb_adr_i == `OFS_CPU;

  // write-once option registers
  wire wr_opt1 = wr_w & hit_opt1 & wb_sel_i[0] & ~opt1_lock_q;
  wire wr_opt2 = wr_w & hit_opt2 & wb_sel_i[0] & ~opt2_lock_q;
  wire wr_cause = wr_w & hit_cause;
  wire unmask_w = wr_w & hit_cpu & wb_sel_i[0]
                  & wb_dat_i[`CPU_UNMASK_BIT];

  // watchdog service events
  wire wdog_clr = wr_cause | wr_opt1 | wr_opt2;

  // reset sources
  wire in_hold = state_q == ST_HOLD;
  wire init_w  = rst_i | in_hold;
  wire pin_req = ~ext_reset_n_i & opt1_q[`OPT1_PINRST_BIT];
  wire req_w   = por_i | low_voltage_reset_i | pin_req | wdog_ovf
                 | bad_opcode_reset_i | bad_address_reset_i
                 | debug_force_reset_i;

  // one cause bit per source; debug force has none
  wire [7:0] cause_now;
  assign cause_now[`CAUSE_POR_BIT]    = por_i;
  assign cause_now[`CAUSE_PIN_BIT]    = pin_req;
  assign cause_now[`CAUSE_WDOG_BIT]   = wdog_ovf;
  assign cause_now[`CAUSE_BADOP_BIT]  = bad_opcode_reset_i;
  assign cause_now[`CAUSE_BADADR_BIT] = bad_address_reset_i;
  assign cause_now[2]                 = 1'b0;
  assign cause_now[`CAUSE_LVD_BIT]    = low_voltage_reset_i;
  assign cause_now[0]                 = 1'b0;

  // read data
  wire [31:0] rd_cause = {24'h0, cause_q};
  wire [31:0] rd_opt1  = {24'h0, opt1_q};
  wire [31:0] rd_opt2  = {24'h0, opt2_q};
  wire [31:0] rd_ioctl = {15'h0, ioctl_q};
  wire [31:0] rd_cpu   = {14'h0, run_q, mask_q, pc_q};
  wire [31:0] rd_w = hit_cause ? rd_cause
                   : hit_opt1  ? rd_opt1
                   : hit_opt2  ? rd_opt2
                   : hit_ioctl ? rd_ioctl
                   : hit_cpu   ? rd_cpu
                   : 32'h0;

  // reset sequencer
  always_comb
  begin
    state_d = state_q;
    hold_d  = hold_q;
    unique case (state_q)
      ST_HOLD:
      begin
        if (hold_q == '0)
        begin
          state_d = ST_FETCH_HI;
        end
        else
        begin
          hold_d = hold_q - `HOLD_W'(1);
        end
      end
      ST_FETCH_HI:
      begin
        state_d = ST_FETCH_LO;
      end
      ST_FETCH_LO:
      begin
        state_d = ST_LOAD;
      end
      ST_LOAD:
      begin
        state_d = ST_RUN;
      end
      ST_RUN:
      begin
        state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_HOLD;
        hold_d  = HOLD_LAST;
      end
    endcase
    if (rst_i | req_w)
    begin
      state_d = ST_HOLD;
      hold_d  = HOLD_LAST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    state_q  <= state_d;
    hold_q   <= hold_d;
    sysrst_q <= state_d == ST_HOLD;
    run_q    <= state_d == ST_RUN;
  end

  // vector fetch, one-cycle read latency
  always_ff @(posedge clk_i)
  begin
    mrd_q   <= (state_d == ST_FETCH_HI) | (state_d == ST_FETCH_LO);
    maddr_q <= (state_d == ST_FETCH_LO) ? `VECTOR_LO_ADDR
                                        : `VECTOR_HI_ADDR;
  end

  always_ff @(posedge clk_i)
  begin
    if (init_w)
    begin
      pc_q <= '0;
    end
    else if (state_q == ST_FETCH_LO)
    begin
      pc_q[15:8] <= mem_rdata_i;
    end
    else if (state_q == ST_LOAD)
    begin
      pc_q[7:0] <= mem_rdata_i;
    end
  end

  // stack pointer and interrupt mask
  always_ff @(posedge clk_i)
  begin
    if (init_w)
    begin
      sp_q   <= `STACK_RESET;
      mask_q <= 1'b1;
    end
    else if (unmask_w)
    begin
      mask_q <= 1'b0;
    end
  end

  // reset cause capture, reset outside hold replaces old causes, one during hold adds to them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cause_q <= `CAUSE_POR_ONLY;
    end
    else if (req_w & ~in_hold)
    begin
      cause_q <= cause_now;
    end
    else if (req_w)
    begin
      cause_q <= cause_q | cause_now;
    end
  end

  // option registers
  always_ff @(posedge clk_i)
  begin
    if (init_w)
    begin
      opt1_q      <= `OPT1_RESET;
      opt2_q      <= `OPT2_RESET;
      opt1_lock_q <= 1'b0;
      opt2_lock_q <= 1'b0;
    end
    else
    begin
      if (wr_opt1)
      begin
        opt1_q      <= wb_dat_i[7:0];
        opt1_lock_q <= 1'b1;
      end
      if (wr_opt2)
      begin
        opt2_q      <= wb_dat_i[7:0];
        opt2_lock_q <= 1'b1;
      end
    end
  end

  // peripheral and pin control, forced off in reset
  always_ff @(posedge clk_i)
  begin
    if (init_w)
    begin
      ioctl_q <= `IOCTL_RESET;
    end
    else if (wr_w & hit_ioctl)
    begin
      if (wb_sel_i[0])
      begin
        ioctl_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        ioctl_q[15:8] <= wb_dat_i[15:8];
      end
      if (wb_sel_i[2])
      begin
        ioctl_q[16] <= wb_dat_i[16];
      end
    end
  end

  // 1 khz internal source
  always_ff @(posedge clk_i)
  begin
    if (rst_i | lpo_q == LPO_LAST)
    begin
      lpo_q <= '0;
    end
    else
    begin
      lpo_q <= lpo_q + `LPO_W'(1);
    end
    tick_q <= ~rst_i & (lpo_q == LPO_LAST);
  end

  wdog_counter u_wdog
  (
    .clk_i          (clk_i),
    .rst_i          (init_w),
    .tick_1k_i      (tick_q),
    .clock_select_i (opt2_q[`OPT2_CLKSEL_BIT]),
    .timeout_long_i (opt1_q[`OPT1_LONG_BIT]),
    .enable_i       (opt1_q[`OPT1_EN_BIT]),
    .debug_i        (debug_mode_i),
    .stop_i         (stop_mode_i),
    .clear_i        (wdog_clr),
    .overflow_o     (wdog_ovf)
  );

  // wishbone classic slave, ack one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= acc_w;
      dat_q <= acc_w ? rd_w : 32'h0;
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign mem_addr_o      = maddr_q;
  assign mem_rd_o        = mrd_q;
  assign system_reset_o  = sysrst_q;
  assign cpu_run_o       = run_q;
  assign pc_o            = pc_q;
  assign stack_pointer_o = sp_q;
  assign int_mask_o      = mask_q;
  assign periph_enable_o = ioctl_q[`IOCTL_PERIPH_BIT];
  assign pin_oe_o        = ioctl_q[7:0];
  assign pin_pullup_o    = ioctl_q[15:8];

endmodule

/* File: tb/cop_asserts.sv */
module cop_asserts
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        ext_reset_n_i,
  input wire logic        por_i,
  input wire logic        low_voltage_reset_i,
  input wire logic        bad_opcode_reset_i,
  input wire logic        bad_address_reset_i,
  input wire logic        debug_force_reset_i,
  input wire logic        debug_mode_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_rd_o,
  input wire logic        system_reset_o,
  input wire logic        cpu_run_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic        int_mask_o,
  input wire logic        periph_enable_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  pin_pullup_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic src = por_i | low_voltage_reset_i | bad_opcode_reset_i
                 | bad_address_reset_i | debug_force_reset_i;
  wire logic quiet = !src && ext_reset_n_i;

  a_source_reset: assert property (
    src |=> system_reset_o) else $error("source gave no reset");
  a_hold_len: assert property (
    $rose(system_reset_o) |-> system_reset_o[*7])
    else $error("reset hold too short");
  a_vector_order: assert property (
    $rose(mem_rd_o) |-> mem_addr_o == 16'hfffe
    ##1 mem_rd_o && mem_addr_o == 16'hffff) else $error("vector order");
  a_run_state: assert property (
    $rose(cpu_run_o) |-> stack_pointer_o == 16'h00ff && int_mask_o)
    else $error("stack or mask wrong at run");
  a_reset_pins: assert property (
    system_reset_o && $past(system_reset_o, 2) |-> !periph_enable_o
    && pin_oe_o == 8'h00 && pin_pullup_o == 8'h00)
    else $error("pins not released in reset");
  a_run_low: assert property (
    system_reset_o && $past(system_reset_o) |-> !cpu_run_o)
    else $error("cpu runs in reset");
  a_debug_freeze: assert property (
    (debug_mode_i && quiet)[*3] ##0 !system_reset_o |=> !system_reset_o)
    else $error("watchdog fired in debug");
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
endmodule

bind cop_watchdog_reset_control cop_asserts chk
(
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ext_reset_n_i, .por_i,
  .low_voltage_reset_i, .bad_opcode_reset_i, .bad_address_reset_i,
  .debug_force_reset_i, .debug_mode_i, .mem_addr_o, .mem_rd_o,
  .system_reset_o, .cpu_run_o, .stack_pointer_o, .int_mask_o,
  .periph_enable_o, .pin_oe_o, .pin_pullup_o
);

/* File: tb/tb_cop_watchdog_reset_control.sv */
`include "cop_defs.svh"

module tb_cop_watchdog_reset_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic        dbg   = 1'b0;
  logic        stp   = 1'b0;
  logic [3:0]  sel   = 4'h0;
  logic [5:0]  src   = 6'h00;
  logic [7:0]  adr   = 8'h00;
  logic [7:0]  mrd   = 8'h00;
  logic [31:0] dat   = 32'h0;
  logic [31:0] rdat, r;
  logic [15:0] maddr, pc, sp;
  logic [7:0]  oe, pu;
  logic        ack, mrdo, sysr, run, imask, pen;
  int          bad_count = 0;
  int          tests_run = 0;
  int          n;
  logic [7:0]  cause_exp [6] = '{8'h40, 8'h80, 8'h02, 8'h10, 8'h08, 8'h00};

  initial forever #2 clk_i = ~clk_i;
  // vector bytes 12 then 34
  always @(posedge clk_i) mrd <= maddr[0] ? 8'h34 : 8'h12;

  cop_watchdog_reset_control #(.LPO_DIVIDE(8)) dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ext_reset_n_i(~src[0]),
    .por_i(src[1]), .low_voltage_reset_i(src[2]),
    .bad_opcode_reset_i(src[3]), .bad_address_reset_i(src[4]),
    .debug_force_reset_i(src[5]), .debug_mode_i(dbg), .stop_mode_i(stp),
    .mem_rdata_i(mrd), .mem_addr_o(maddr), .mem_rd_o(mrdo),
    .system_reset_o(sysr), .cpu_run_o(run), .pc_o(pc),
    .stack_pointer_o(sp), .int_mask_o(imask), .periph_enable_o(pen),
    .pin_oe_o(oe), .pin_pullup_o(pu)
  );

  task summarize;
    $display("tests %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task fail;
    bad_count++;
    summarize;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    n = 0;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
    r = rdat;
    if (ack !== 1'b1) fail;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  task wait_run;
    tick(3);
    n = 0;
    do @(posedge clk_i); while (run !== 1'b1 && ++n < 300);
    if (run !== 1'b1) fail;
  endtask

  // cycles until the watchdog reset shows
  task ovf(input int lo, input int hi);
    n = 0;
    do @(posedge clk_i); while (sysr !== 1'b1 && ++n < hi + 5);
    chk(n >= lo && n <= hi, 1);
  endtask

  task pulse(input int k);
    @(posedge clk_i);
    src[k] <= 1'b1;
    @(posedge clk_i);
    src[k] <= 1'b0;
  endtask

  initial
  begin
    tick(10);
    rst_i <= 1'b0;
    wait_run;
    chk(pc, 16'h1234);
    chk(sp, 16'h00ff);
    chk(imask, 1);
    chk({pen, oe, pu}, 0);
    wb(1, `OFS_CPU, 32'h1);
    chk(imask, 0);
    wb(0, `OFS_CPU, 0);
    chk(r, 32'h00021234);
    wb(0, `OFS_CAUSE, 0);
    chk(r, 32'h80);
    wb(0, `OFS_OPT1, 0);
    chk(r, 32'hc0);
    wb(0, `OFS_OPT2, 0);
    chk(r, 32'h00);
    wb(0, 8'h3c, 0);
    chk(r, 32'h00);
    ovf(2000, 2070);
    wait_run;
    chk(imask, 1);
    wb(0, `OFS_CAUSE, 0);
    chk(r, 32'h20);
    wb(1, `OFS_OPT2, 32'h80);
    wb(1, `OFS_OPT1, 32'h80);
    wb(1, `OFS_OPT1, 32'hc2);
    wb(1, `OFS_OPT2, 32'h00);
    repeat (3)
    begin
      tick(6000);
      wb(1, `OFS_CAUSE, 32'hff);
    end
    wb(0, `OFS_OPT1, 0);
    chk(r, 32'h80);
    wb(0, `OFS_OPT2, 0);
    chk(r, 32'h80);
    wb(0, `OFS_CAUSE, 0);
    chk(r, 32'h20);
    ovf(8180, 8200);
    wait_run;
    pulse(0);
    tick(3);
    chk(sysr, 0);
    wb(1, `OFS_OPT1, 32'h42);
    wb(1, `OFS_IOCTL, 32'h0001a55c);
    tick(2200);
    chk({pen, oe, pu}, 17'h15ca5);
    pulse(0);
    wait_run;
    chk({pen, oe, pu}, 0);
    for (int k = 0; k < 6; k++)
    begin
      if (k > 0) pulse(k);
      if (k > 0) wait_run;
      wb(0, `OFS_CAUSE, 0);
      chk(r, cause_exp[k]);
    end
    wb(1, `OFS_OPT1, 32'h80);
    dbg <= 1'b1;
    tick(3000);
    dbg <= 1'b0;
    wb(0, `OFS_CAUSE, 0);
    chk(r, 32'h00);
    ovf(230, 270);
    wait_run;
    wb(1, `OFS_OPT2, 32'h80);
    wb(1, `OFS_OPT1, 32'h80);
    tick(4000);
    stp <= 1'b1;
    tick(6000);
    stp <= 1'b0;
    ovf(4150, 4220);
    wait_run;
    wb(1, `OFS_OPT1, 32'h80);
    tick(200);
    stp <= 1'b1;
    tick(50);
    stp <= 1'b0;
    ovf(235, 270);
    wait_run;
    summarize;
  end
endmodule
